// [design/dpwrs_pkg.sv]
// Purpose: shared constants and types for the dual pot wiper register store
// Assumes: core clock 50 MHz; serial front end decodes bytes on the link clock
// Notes: opcodes sit in the upper nibble of the instruction byte
`default_nettype none
package dpwrs_pkg;
  localparam int NPOTS = 2;
  localparam int WIPER_W = 6;
  localparam int NTAPS = 64;
  localparam int NSLOTS = 4;
  localparam int SLOT_W = 2;
  localparam int INSTR_W = 8;
  localparam int NV_CNT_W = 20;
  // instruction byte fields
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int POT_BIT = 2;
  localparam int SLOT_MSB = 1;
  localparam int SLOT_LSB = 0;
  // opcodes
  localparam logic [3:0] OPC_RD_WIPER = 4'h9;
  localparam logic [3:0] OPC_WR_WIPER = 4'hA;
  localparam logic [3:0] OPC_RD_SLOT = 4'hB;
  localparam logic [3:0] OPC_WR_SLOT = 4'hC;
  localparam logic [3:0] OPC_SLOT_TO_WIPER = 4'hD;
  localparam logic [3:0] OPC_WIPER_TO_SLOT = 4'hE;
  localparam logic [3:0] OPC_ALL_SLOT_TO_WIPER = 4'h1;
  localparam logic [3:0] OPC_ALL_WIPER_TO_SLOT = 4'h8;
  localparam logic [3:0] OPC_STEP = 4'h2;
  // wiper limits and reset values
  localparam logic [WIPER_W-1:0] WIPER_MAX = 6'h3F;
  localparam logic [WIPER_W-1:0] WIPER_MIN = 6'h00;
  localparam logic [WIPER_W-1:0] WIPER_ONE = 6'h01;
  localparam logic [WIPER_W-1:0] WIPER_RESET = 6'h00;
  localparam logic [SLOT_W-1:0] POWER_ON_SETTING_SLOT = 2'h0;
  // nonvolatile write time
  localparam int NV_WRITE_MS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int CLK_PERIOD_NS = 20;

  typedef struct packed {
    logic [INSTR_W-1:0] instr;
    logic [WIPER_W-1:0] data;
  } dpwrs_cmd_t;

  typedef struct packed {
    logic is_step;
    logic step_up;
    logic [INSTR_W-1:0] instr;
    logic [WIPER_W-1:0] data;
  } dpwrs_xfer_t;

  typedef enum logic [1:0] {
    ST_RECALL = 2'b00,
    ST_IDLE = 2'b01,
    ST_NVWR = 2'b11
  } dpwrs_state_t;
endpackage : dpwrs_pkg
`default_nettype wire

// [design/dpwrs_wiper.sv]
// Purpose: one pot's volatile wiper counter with one-hot tap select
// Assumes: load has priority over a step in the same cycle
// Notes: saturates at both ends instead of wrapping
`default_nettype none
module dpwrs_wiper (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic load_en_in,
  input wire logic [dpwrs_pkg::WIPER_W-1:0] load_val_in,
  input wire logic step_en_in,
  input wire logic step_up_in,
  output logic [dpwrs_pkg::WIPER_W-1:0] pos_out,
  output logic [dpwrs_pkg::NTAPS-1:0] taps_out
);
  import dpwrs_pkg::*;

  logic [WIPER_W-1:0] next_pos;
  wire logic at_top = (pos_out == WIPER_MAX);
  wire logic at_bot = (pos_out == WIPER_MIN);
  wire logic go_up = step_en_in && step_up_in && !at_top;
  wire logic go_down = step_en_in && !step_up_in && !at_bot;

  // parallel/serial load, else single step
  assign next_pos = load_en_in ? load_val_in :
                    go_up ? pos_out + WIPER_ONE :
                    go_down ? pos_out - WIPER_ONE : pos_out;

  // counter is volatile, lost on reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) pos_out <= WIPER_RESET;
    else pos_out <= next_pos;
  end

  // one tap switch closed per position
  for (genvar i = 0; i < NTAPS; i++) begin : g_tap
    always_ff @(posedge clk_in) begin
      if (!rst_b_in) taps_out[i] <= (WIPER_RESET == WIPER_W'(i));
      else taps_out[i] <= (next_pos == WIPER_W'(i));
    end
  end

  chk_tap_onehot: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ##1 (taps_out == (NTAPS'(1) << pos_out))) else $error("tap select not one-hot of position");
  chk_step_single: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (step_en_in && !load_en_in && step_up_in && !at_top) |=> (pos_out == $past(pos_out) + WIPER_ONE))
    else $error("step up moved other than one tap");
  chk_sat_ends: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (step_en_in && !load_en_in && ((step_up_in && at_top) || (!step_up_in && at_bot))) |=> $stable(pos_out))
    else $error("wiper wrapped at an end");
endmodule : dpwrs_wiper
`default_nettype wire

// [design/dpwrs_store.sv]
// Purpose: dual pot wiper and setting-slot store behind the serial decoder
// Assumes: decoder strobes arrive on link_clk_in; storage runs on clk_in
// Notes: slot array is nonvolatile, untouched by reset
`default_nettype none
module dpwrs_store #(
  parameter int unsigned NV_WRITE_CYCLES = dpwrs_pkg::NV_WRITE_MS * dpwrs_pkg::NS_PER_MS / dpwrs_pkg::CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic link_clk_in,
  input wire logic cmd_valid_in,
  input wire dpwrs_pkg::dpwrs_cmd_t cmd_in,
  input wire logic step_in,
  input wire logic step_up_in,
  output logic busy_nack_out,
  output logic [dpwrs_pkg::WIPER_W-1:0] read_data_out,
  output logic [dpwrs_pkg::NPOTS*dpwrs_pkg::WIPER_W-1:0] wiper_pos_out,
  output logic [dpwrs_pkg::NPOTS*dpwrs_pkg::NTAPS-1:0] tap_select_out
);
  import dpwrs_pkg::*;

  // ---------------- link clock domain ----------------
  logic link_rst_meta;
  logic link_rst_b;
  logic busy_meta;
  logic req_tog;
  logic armed;
  dpwrs_xfer_t xfer_q;
  dpwrs_xfer_t next_xfer;
  logic nv_busy;

  // reset release into the link domain
  always_ff @(posedge link_clk_in) begin
    link_rst_meta <= rst_b_in;
    link_rst_b <= link_rst_meta;
  end

  // busy level back to the link side
  always_ff @(posedge link_clk_in) begin
    busy_meta <= nv_busy;
    busy_nack_out <= busy_meta;
  end

  wire logic accept = cmd_valid_in && !busy_nack_out;
  wire logic step_ok = step_in && armed && !busy_nack_out && !cmd_valid_in;
  wire logic step_opc = (cmd_in.instr[OPC_MSB:OPC_LSB] == OPC_STEP);
  assign next_xfer = accept ? '{is_step: 1'b0, step_up: 1'b0, instr: cmd_in.instr, data: cmd_in.data} :
                     '{is_step: 1'b1, step_up: step_up_in, instr: xfer_q.instr, data: xfer_q.data};

  // capture a command or step, flip the request toggle
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      req_tog <= 1'b0;
      armed <= 1'b0;
      xfer_q <= '0;
    end else if (accept || step_ok) begin
      req_tog <= ~req_tog;
      xfer_q <= next_xfer;
      armed <= accept ? step_opc : armed;
    end
  end

  // ---------------- core clock domain ----------------
  dpwrs_state_t state;
  dpwrs_state_t next_state;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic cmd_go;
  dpwrs_xfer_t cap;
  logic [NV_CNT_W-1:0] nv_cnt;
  logic [WIPER_W-1:0] slots [NPOTS][NSLOTS] = '{default: '{default: WIPER_RESET}}; // erased once, reset leaves it
  logic [WIPER_W-1:0] pos [NPOTS];

  // toggle crossing, cmd word is stable while the toggle travels
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
      cmd_go <= 1'b0;
      cap <= '0;
    end else begin
      tog_meta <= req_tog;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      cmd_go <= tog_sync ^ tog_seen;
      cap <= (tog_sync ^ tog_seen) ? xfer_q : cap;
    end
  end

  // instruction byte fields
  wire logic [3:0] opc = cap.instr[OPC_MSB:OPC_LSB];
  wire logic pot = cap.instr[POT_BIT];
  wire logic [SLOT_W-1:0] slot = cap.instr[SLOT_MSB:SLOT_LSB];
  wire logic recall = (state == ST_RECALL);
  wire logic go = cmd_go && (state == ST_IDLE);
  wire logic go_instr = go && !cap.is_step;
  wire logic wr_slot = go_instr && (opc == OPC_WR_SLOT);
  wire logic to_slot = go_instr && (opc == OPC_WIPER_TO_SLOT);
  wire logic all_to_slot = go_instr && (opc == OPC_ALL_WIPER_TO_SLOT);
  wire logic nv_start = wr_slot || to_slot || all_to_slot;
  wire logic cnt_done = (nv_cnt == '0);

  // per-pot wiper counters and load selection
  for (genvar p = 0; p < NPOTS; p++) begin : g_pot
    wire logic mine = (pot == 1'(p));
    wire logic ld_direct = go_instr && mine && (opc == OPC_WR_WIPER);
    wire logic ld_slot = go_instr && ((mine && opc == OPC_SLOT_TO_WIPER) ||
                                      opc == OPC_ALL_SLOT_TO_WIPER);
    wire logic load_en = recall || ld_direct || ld_slot;
    wire logic [WIPER_W-1:0] load_val = recall ? slots[p][POWER_ON_SETTING_SLOT] :
                                        ld_direct ? cap.data : slots[p][slot];
    wire logic step_en = go && cap.is_step && mine;

    dpwrs_wiper u_wiper (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .load_en_in(load_en),
      .load_val_in(load_val),
      .step_en_in(step_en),
      .step_up_in(cap.step_up),
      .pos_out(pos[p]),
      .taps_out(tap_select_out[p*NTAPS +: NTAPS])
    );
    assign wiper_pos_out[p*WIPER_W +: WIPER_W] = pos[p];
  end

  // slot array writes; wiper untouched by these
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NPOTS; p++) begin
      if (wr_slot && pot == 1'(p)) slots[p][slot] <= cap.data;
      else if ((to_slot && pot == 1'(p)) || all_to_slot) slots[p][slot] <= pos[p];
    end
  end

  // read answer for the serial front end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) read_data_out <= WIPER_RESET;
    else if (go_instr && opc == OPC_RD_WIPER) read_data_out <= pos[pot];
    else if (go_instr && opc == OPC_RD_SLOT) read_data_out <= slots[pot][slot];
  end

  // recall once, then idle; nonvolatile writes hold busy
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RECALL: next_state = ST_IDLE;
      ST_IDLE: next_state = nv_start ? ST_NVWR : ST_IDLE;
      ST_NVWR: next_state = cnt_done ? ST_IDLE : ST_NVWR;
      default: next_state = ST_RECALL;
    endcase
  end

  // state, write timer and busy level
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= ST_RECALL;
      nv_cnt <= '0;
      nv_busy <= 1'b0;
    end else begin
      state <= next_state;
      nv_cnt <= nv_start ? NV_CNT_W'(NV_WRITE_CYCLES - 1) : (cnt_done ? nv_cnt : nv_cnt - 1'b1);
      nv_busy <= (next_state == ST_NVWR);
    end
  end

  chk_direct_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (go_instr && opc == OPC_WR_WIPER && !pot) |=> (pos[0] == $past(cap.data)))
    else $error("direct wiper write not loaded");
  chk_slot_load: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (go_instr && opc == OPC_SLOT_TO_WIPER && pot) |=> (pos[1] == $past(slots[1][slot])))
    else $error("slot to wiper transfer wrong");
  chk_recall_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state == ST_RECALL && rst_b_in) |=>
      (pos[0] == $past(slots[0][POWER_ON_SETTING_SLOT])) && (state == ST_IDLE))
    else $error("power-up recall wrong");
  chk_nv_busy: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    nv_start |=> nv_busy ##1 (nv_busy && nv_cnt == NV_CNT_W'(NV_WRITE_CYCLES - 2)))
    else $error("nonvolatile write busy not started");
  chk_nv_end: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state == ST_NVWR && cnt_done) |=> (!nv_busy && state == ST_IDLE))
    else $error("nonvolatile write busy overran");
  chk_slot_store: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_slot && !pot) |=> (slots[0][$past(slot)] == $past(cap.data)) && $stable(pos[0]))
    else $error("slot write lost or moved wiper");
  chk_wiper_to_slot: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    to_slot |=> (slots[$past(pot)][$past(slot)] == $past(pos[pot])))
    else $error("wiper to slot copy wrong");
  chk_busy_refuse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state == ST_NVWR && cmd_go) |=> ($stable(pos[0]) && $stable(pos[1])))
    else $error("command acted during nonvolatile write");
  chk_step_pot: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (go && cap.is_step && !pot) |=> $stable(pos[1]))
    else $error("step moved the other pot");
  chk_global_load: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (go_instr && opc == OPC_ALL_SLOT_TO_WIPER) |=>
      (pos[0] == $past(slots[0][slot]) && pos[1] == $past(slots[1][slot])))
    else $error("global slot to wiper transfer wrong");
  chk_read_answer: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (go_instr && opc == OPC_RD_SLOT) |=> (read_data_out == $past(slots[pot][slot])))
    else $error("slot read answer wrong");
  chk_recall_one: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state == ST_RECALL && rst_b_in) |=> (pos[1] == $past(slots[1][POWER_ON_SETTING_SLOT])))
    else $error("power-up recall of second pot wrong");
  chk_link_refuse: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
    ((cmd_valid_in && busy_nack_out) || (step_in && !armed && !cmd_valid_in)) |=> $stable(req_tog))
    else $error("refused request was passed on");
endmodule : dpwrs_store
`default_nettype wire

// [tb/dpwrs_host.sv]
// Purpose: host model driving decoded commands and steps on the link clock
// Assumes: busy flag is sampled mid link cycle, away from its edge
// Notes: idle command lines show the inverted last value
`default_nettype none
module dpwrs_host (
  input wire logic link_clk_in,
  input wire logic busy_nack_in,
  output logic cmd_valid_out,
  output dpwrs_pkg::dpwrs_cmd_t cmd_out,
  output logic step_out,
  output logic step_up_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dpwrs_pkg::*;
  // quiet lines at time zero
  initial begin
    cmd_valid_out = 1'h0;
    cmd_out = '0;
    step_out = 1'h0;
    step_up_out = 1'h0;
  end
  // polls out a nonvolatile write, then sends one whole instruction
  task automatic send(input logic [3:0] opc, input logic pot, input logic [1:0] slot,
                      input logic [5:0] val, input bit poll, output bit ok);
    ok = 1'h1;
    for (int i = 0; poll && i < 100; i++) begin
      @(negedge link_clk_in);
      ok = !busy_nack_in;
      if (ok) break;
    end
    @(posedge link_clk_in);
    cmd_valid_out <= 1'h1;
    cmd_out <= '{instr: {opc, 1'h0, pot, slot}, data: val};
    @(posedge link_clk_in);
    cmd_valid_out <= 1'h0;
    cmd_out <= ~cmd_out;
  endtask : send
  // one step pulse, direction level beside it
  task automatic step(input logic up);
    @(posedge link_clk_in);
    step_out <= 1'h1;
    step_up_out <= up;
    @(posedge link_clk_in);
    step_out <= 1'h0;
    step_up_out <= ~up;
  endtask : step
endmodule : dpwrs_host
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench for the dual pot wiper store
// Assumes: shortened nonvolatile write of 60 core cycles
// Notes: reset check and two direct wiper writes first, then table rows, steps, refusal and recall
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dpwrs_pkg::*;
  typedef struct packed {
    logic [3:0] opc;
    logic pot;
    logic [1:0] slot;
    logic [5:0] val;
    logic rd_chk;
    logic [5:0] w0;
    logic [5:0] w1;
    logic [5:0] rd;
  } dpwrs_row_t;
  logic clk_in = 1'h0;
  logic link_clk = 1'h0;
  logic rst_b = 1'h0;
  logic cmd_valid;
  dpwrs_cmd_t cmd;
  logic step;
  logic step_up;
  logic busy_nack;
  logic [5:0] read_data;
  logic [11:0] wiper_pos;
  logic [127:0] tap_select;
  int miscompares = 0;
  int checks = 0;
  bit ok;
  // core clock and an unrelated link clock
  always #10 clk_in = ~clk_in;
  initial #7 forever #80 link_clk = ~link_clk;
  dpwrs_store #(.NV_WRITE_CYCLES(60)) dpwrs_store_i (
    .clk_in(clk_in), .rst_b_in(rst_b), .link_clk_in(link_clk),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .step_in(step), .step_up_in(step_up),
    .busy_nack_out(busy_nack), .read_data_out(read_data),
    .wiper_pos_out(wiper_pos), .tap_select_out(tap_select));
  dpwrs_host host_i (
    .link_clk_in(link_clk), .busy_nack_in(busy_nack), .cmd_valid_out(cmd_valid),
    .cmd_out(cmd), .step_out(step), .step_up_out(step_up));
  // ordinary cases: command, then expected wipers and read answer
  localparam dpwrs_row_t ROWS [13] = '{
    '{4'hC, 1'h0, 2'h0, 6'h2A, 1'h0, 6'h15, 6'h3E, 6'h00},
    '{4'hC, 1'h1, 2'h3, 6'h07, 1'h0, 6'h15, 6'h3E, 6'h00},
    '{4'hB, 1'h0, 2'h0, 6'h00, 1'h1, 6'h15, 6'h3E, 6'h2A},
    '{4'hB, 1'h1, 2'h3, 6'h00, 1'h1, 6'h15, 6'h3E, 6'h07},
    '{4'hD, 1'h1, 2'h3, 6'h00, 1'h0, 6'h15, 6'h07, 6'h00},
    '{4'h9, 1'h1, 2'h0, 6'h00, 1'h1, 6'h15, 6'h07, 6'h07},
    '{4'hE, 1'h0, 2'h1, 6'h00, 1'h0, 6'h15, 6'h07, 6'h00},
    '{4'hB, 1'h0, 2'h1, 6'h00, 1'h1, 6'h15, 6'h07, 6'h15},
    '{4'hA, 1'h0, 2'h0, 6'h3F, 1'h0, 6'h3F, 6'h07, 6'h00},
    '{4'h8, 1'h0, 2'h2, 6'h00, 1'h0, 6'h3F, 6'h07, 6'h00},
    '{4'hA, 1'h1, 2'h0, 6'h00, 1'h0, 6'h3F, 6'h00, 6'h00},
    '{4'h1, 1'h0, 2'h2, 6'h00, 1'h0, 6'h3F, 6'h07, 6'h00},
    '{4'hC, 1'h1, 2'h0, 6'h11, 1'h0, 6'h3F, 6'h07, 6'h00}};
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic give_up;
    miscompares++;
    summarize();
  endtask : give_up
  task automatic cmp_word(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  // wiper pair and its one-hot tap vector
  task automatic check_pots(input logic [5:0] w0, input logic [5:0] w1);
    cmp_word(wiper_pos, {w1, w0});
    cmp_word(tap_select, (128'h1 << w0) | (128'h1 << (7'h40 + {1'h0, w1})));
  endtask : check_pots
  task automatic links(input int n);
    repeat (n) @(posedge link_clk);
  endtask : links
  // lets a command land, bounded wait on busy
  task automatic settle;
    int i;
    links(3);
    for (i = 0; i < 100 && busy_nack !== 1'h0; i++) @(negedge link_clk);
    if (i == 100) give_up();
    links(1);
  endtask : settle
  task automatic do_cmd(input logic [3:0] opc, input logic pot, input logic [1:0] slot, input logic [5:0] val);
    host_i.send(opc, pot, slot, val, 1'h1, ok);
    if (!ok) give_up();
    settle();
  endtask : do_cmd
  // main sequence
  initial begin
    repeat (47) @(posedge clk_in);
    check_pots(6'h00, 6'h00);
    cmp_word(read_data, 6'h00);
    @(posedge clk_in);
    rst_b <= 1'h1;
    links(4);
    do_cmd(4'hA, 1'h0, 2'h0, 6'h15);
    do_cmd(4'hA, 1'h1, 2'h0, 6'h3E);
    check_pots(6'h15, 6'h3E);
    foreach (ROWS[i]) begin
      do_cmd(ROWS[i].opc, ROWS[i].pot, ROWS[i].slot, ROWS[i].val);
      check_pots(ROWS[i].w0, ROWS[i].w1);
      if (ROWS[i].rd_chk) cmp_word(read_data, ROWS[i].rd);
    end
    do_cmd(4'h2, 1'h0, 2'h0, 6'h00);
    host_i.step(1'h1);
    settle();
    check_pots(6'h3F, 6'h07);
    host_i.step(1'h0);
    host_i.step(1'h0);
    settle();
    check_pots(6'h3D, 6'h07);
    host_i.send(4'hC, 1'h0, 2'h3, 6'h01, 1'h1, ok);
    host_i.send(4'hA, 1'h0, 2'h0, 6'h00, 1'h0, ok);
    @(negedge link_clk);
    cmp_word(busy_nack, 1'h1);
    host_i.send(4'hA, 1'h1, 2'h0, 6'h00, 1'h0, ok);
    settle();
    host_i.step(1'h0);
    settle();
    check_pots(6'h3D, 6'h07);
    @(posedge clk_in);
    rst_b <= 1'h0;
    repeat (48) @(posedge clk_in);
    check_pots(6'h00, 6'h00);
    rst_b <= 1'h1;
    links(4);
    check_pots(6'h2A, 6'h11);
    summarize();
  end
endmodule : testbench
`default_nettype wire
